/* File: rtl/loop_detector_pkg.sv */
/*
 * Constants, register map and types shared by the dual loop vehicle detector.
 * Assumes a 100 MHz system clock from which the 20 MHz time base is derived.
 */
`default_nettype none

package loop_detector_pkg;

    // ------------------------------------------------------------------
    // Clocking and time base
    // ------------------------------------------------------------------
    localparam int CLK_HZ       = 100_000_000;
    localparam int TIMEBASE_HZ  = 20_000_000;
    localparam int TICK_DIV     = CLK_HZ / TIMEBASE_HZ;
    localparam logic [2:0] TICK_DIV_LAST = 3'(TICK_DIV - 1);
    localparam int MS_CYCLES    = CLK_HZ / 1000;

    // ------------------------------------------------------------------
    // Measurement
    // ------------------------------------------------------------------
    localparam int CNT_W             = 24;
    localparam int EDGE_W            = 16;
    localparam int MS_W              = 12;
    localparam int BASE_SAMPLE_US    = 500;
    localparam logic [CNT_W-1:0] BASE_SAMPLE_TICKS =
        CNT_W'(TIMEBASE_HZ / 1_000_000 * BASE_SAMPLE_US);
    localparam int MAX_LOOP_HZ       = 200_000;
    localparam logic [CNT_W-1:0] SHORT_MIN_TICKS = CNT_W'(TIMEBASE_HZ / MAX_LOOP_HZ);
    localparam logic [MS_W-1:0] OPEN_TIMEOUT_MS = 12'h0002;
    localparam int THRESH_SHIFT_BASE = 7;

    // ------------------------------------------------------------------
    // Call and indicator timing, in milliseconds
    // ------------------------------------------------------------------
    localparam logic [MS_W-1:0] MIN_HOLD_MS    = 12'h0064;
    localparam logic [MS_W-1:0] PULSE_MS       = 12'h007D;
    localparam logic [MS_W-1:0] FLASH_ON_MS    = 12'h00FA;
    localparam logic [MS_W-1:0] FLASH_GAP_MS   = 12'h00FA;
    localparam logic [MS_W-1:0] FLASH_PAUSE_MS = 12'h03E8;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_REF0    = 8'h08;
    localparam logic [7:0] ADDR_REF1    = 8'h0C;
    localparam int CTRL_REINIT_BIT      = 0;
    localparam int CTRL_DRIFT_HOLD_BIT  = 1;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CH_OFF  = 2'b00,
        CH_TUNE = 2'b01,
        CH_RUN  = 2'b11,
        CH_FAIL = 2'b10
    } ch_state_type;

    typedef enum logic [1:0] {
        FAULT_NONE  = 2'b00,
        FAULT_OPEN  = 2'b01,
        FAULT_SHORT = 2'b10
    } fault_type;

endpackage

`default_nettype wire

/* File: rtl/loop_period_counter.sv */
/*
 * One channel's capture counter: counts time-base ticks over whole loop cycles.
 * Assumes loop_rise is a one-cycle pulse from a synchronised loop signal.
 */
`default_nettype none

module loop_period_counter
    import loop_detector_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              srst,
    input  wire logic              run,
    input  wire logic              tune,
    input  wire logic              tick,
    input  wire logic              ms_tick,
    input  wire logic              loop_rise,
    input  wire logic [CNT_W-1:0]  target_ticks,
    input  wire logic [EDGE_W-1:0] target_edges,
    output logic                   done,
    output logic                   open_fault,
    output logic [CNT_W-1:0]       sample_ticks,
    output logic [EDGE_W-1:0]      sample_edges
);

    logic              started;
    logic [CNT_W-1:0]  ticks;
    logic [EDGE_W-1:0] edges;
    logic [MS_W-1:0]   idle_ms;
    logic              tune_end;
    logic              sample_end;

    // Tuning ends on time, sampling ends on a loop edge, so samples always span
    // whole loop cycles.
    assign tune_end   = tune && started && tick && (ticks + 1'b1 >= target_ticks);
    assign sample_end = !tune && started && loop_rise && (edges + 1'b1 >= target_edges);

    // ------------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        done       <= 1'b0;
        open_fault <= 1'b0;
        if (srst || !run)
        begin
            started <= 1'b0;
            ticks   <= '0;
            edges   <= '0;
            idle_ms <= '0;
        end
        else if (idle_ms > OPEN_TIMEOUT_MS)
        begin
            open_fault <= 1'b1;
            started    <= 1'b0;
            ticks      <= '0;
            edges      <= '0;
            idle_ms    <= '0;
        end
        else
        begin
            if (loop_rise)
                idle_ms <= '0;
            else if (ms_tick)
                idle_ms <= idle_ms + 1'b1;
            if (!started)
            begin
                started <= loop_rise;
            end
            else if (tune_end || sample_end)
            begin
                done         <= 1'b1;
                sample_ticks <= ticks + CNT_W'(tick);
                sample_edges <= edges + EDGE_W'(loop_rise);
                ticks        <= '0;
                edges        <= '0;
                started      <= !tune;
            end
            else
            begin
                ticks <= ticks + CNT_W'(tick);
                edges <= edges + EDGE_W'(loop_rise);
            end
        end
    end

endmodule

`default_nettype wire

/* File: rtl/fail_flasher.sv */
/*
 * Fail indicator pattern generator: single flash for open, double for short.
 * Assumes ms_tick is a one-cycle pulse once per millisecond.
 */
`default_nettype none

module fail_flasher
    import loop_detector_pkg::*;
(
    input  wire logic      ref_clk,
    input  wire logic      srst,
    input  wire logic      ms_tick,
    input  wire fault_type fault,
    output logic           led
);

    logic [MS_W-1:0] phase;
    logic [MS_W-1:0] period;
    logic            second_on;

    assign second_on = (fault == FAULT_SHORT)
                    && (phase >= FLASH_ON_MS + FLASH_GAP_MS)
                    && (phase <  FLASH_ON_MS + FLASH_GAP_MS + FLASH_ON_MS);
    assign period = (fault == FAULT_SHORT)
                  ? FLASH_ON_MS + FLASH_GAP_MS + FLASH_ON_MS + FLASH_PAUSE_MS
                  : FLASH_ON_MS + FLASH_PAUSE_MS;

    always_ff @(posedge ref_clk)
    begin
        if (srst || fault == FAULT_NONE)
        begin
            phase <= '0;
            led   <= 1'b0;
        end
        else
        begin
            if (ms_tick)
                phase <= (phase + 1'b1 >= period) ? '0 : phase + 1'b1;
            led <= (phase < FLASH_ON_MS) || second_on;
        end
    end

endmodule

`default_nettype wire

/* File: rtl/dual_loop_vehicle_detector.sv */
/*
 * Dual inductive loop vehicle detector: period measurement, reference tracking,
 * call, pulse and fail indicator logic, with a Wishbone classic register slave.
 * Assumes squared loop signals and switch/jumper levels arrive asynchronously
 * on pins; a fitted jumper reads as 1 and a switch that is on reads as 1.
 */
// What this block does
// - With hold jumper fitted, presence calls last at least 100 ms.
// - Jumper fitted measures both channels continuously; removed alternates them.
// - Momentary-call switch on selects pulse mode, off selects presence mode.
// - Sensitivity is a binary three-switch value, 1 least, 7 most sensitive.
// - Sensitivity 0 disables the channel; it never calls.
// - Open loop flashes the fail indicator once, then pauses, repeatedly.
// - Shorted loop flashes the fail indicator twice, then pauses, repeatedly.
// - Changing then restoring a momentary-call or sensitivity switch reinitialises both channels and clears faults.
// - A sample counts time-base ticks over whole loop cycles.
// - Presence is declared only when a sample differs enough from the reference.
// - Non-scanning, sensitivity below 4, a sample completes within 2 ms.
// - Higher sensitivity uses longer samples with more loop cycles.
// - Initialisation measures loop frequency, fixing cycles per sample thereafter.
// - Samples outside operating limits give a fail, not a call.
// - The reference follows samples slowly so drift never calls.
// - Call indicator mirrors call output; a separate indicator shows loop faults.
// - A low external reset input resets the whole device.
// - Measurement runs on a 20 MHz time base; each channel has its counter.
`default_nettype none

module dual_loop_vehicle_detector
    import loop_detector_pkg::*;
#(
    parameter int MS_COUNT     = MS_CYCLES,
    parameter int SAMPLE_TICKS = int'(BASE_SAMPLE_TICKS)
)
(
    input  wire logic        ref_clk,
    input  wire logic        srst,
    input  wire logic        ext_reset_n,
    input  wire logic [1:0]  loop_sq,
    input  wire logic        hold_link,
    input  wire logic        scan_link,
    input  wire logic [1:0]  pulse_sw,
    input  wire logic [1:0]  sens_weight_one,
    input  wire logic [1:0]  sens_weight_two,
    input  wire logic [1:0]  sens_weight_four,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    output logic [1:0]       call_out,
    output logic [1:0]       call_led,
    output logic [1:0]       fail_led
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    localparam int PIN_W = 13;
    localparam logic [PIN_W-1:0] PIN_RESET = 13'h1000;

    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] pin_s1;
    logic [PIN_W-1:0] pin_s2;
    logic [PIN_W-1:0] pin_s3;
    logic [PIN_W-1:0] pin;

    assign pin_raw = {ext_reset_n, hold_link, scan_link, pulse_sw, sens_weight_four,
                      sens_weight_two, sens_weight_one, loop_sq};

    // The first stage feeds only the second; a change is taken once the
    // second and third stages agree.
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            pin_s1 <= PIN_RESET;
            pin_s2 <= PIN_RESET;
            pin_s3 <= PIN_RESET;
            pin    <= PIN_RESET;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
            for (int k = 0; k < PIN_W; k++)
                if (pin_s2[k] == pin_s3[k])
                    pin[k] <= pin_s3[k];
        end
    end

    logic       dev_rst;
    logic       hold_fitted;
    logic       scan_fitted;
    logic [1:0] pulse_mode;
    logic [2:0] sens [2];
    logic [1:0] loop_lvl;
    logic [1:0] loop_prev;
    logic [1:0] loop_rise;

    assign dev_rst     = srst || !pin[12];
    assign hold_fitted = pin[11];
    assign scan_fitted = pin[10];
    assign pulse_mode  = pin[9:8];
    assign sens[0]     = {pin[6], pin[4], pin[2]};
    assign sens[1]     = {pin[7], pin[5], pin[3]};
    assign loop_lvl    = pin[1:0];
    assign loop_rise   = loop_lvl & ~loop_prev;

    // ------------------------------------------------------------------
    // Time base and millisecond enables
    // ------------------------------------------------------------------
    logic [2:0]  div_cnt;
    logic        tick;
    logic [31:0] ms_cnt;
    logic        ms_tick;

    always_ff @(posedge ref_clk)
    begin
        if (dev_rst)
        begin
            div_cnt   <= '0;
            tick      <= 1'b0;
            ms_cnt    <= '0;
            ms_tick   <= 1'b0;
            loop_prev <= '0;
        end
        else
        begin
            div_cnt   <= (div_cnt == TICK_DIV_LAST) ? '0 : div_cnt + 1'b1;
            tick      <= (div_cnt == TICK_DIV_LAST);
            ms_cnt    <= (ms_cnt == 32'(MS_COUNT - 1)) ? '0 : ms_cnt + 1'b1;
            ms_tick   <= (ms_cnt == 32'(MS_COUNT - 1));
            loop_prev <= loop_lvl;
        end
    end

    // ------------------------------------------------------------------
    // Register slave
    // ------------------------------------------------------------------
    logic soft_reinit;
    logic drift_hold;
    logic wb_hit;

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // ------------------------------------------------------------------
    // Settings change detection
    // ------------------------------------------------------------------
    logic [7:0] settings;
    logic [7:0] settings_prev;
    logic       reinit;

    assign settings = {pulse_mode, sens[1], sens[0]};

    always_ff @(posedge ref_clk)
    begin
        if (dev_rst)
        begin
            settings_prev <= '0;
            reinit        <= 1'b1;
        end
        else
        begin
            settings_prev <= settings;
            reinit        <= (settings != settings_prev) || soft_reinit;
        end
    end

    // ------------------------------------------------------------------
    // Scanning
    // ------------------------------------------------------------------
    ch_state_type     state      [2];
    fault_type        fault      [2];
    logic [1:0]       active;
    logic [1:0]       run;
    logic [1:0]       done;
    logic [1:0]       open_fault;
    logic [CNT_W-1:0] ticks      [2];
    logic [EDGE_W-1:0] edges     [2];
    logic [CNT_W-1:0] ref_val    [2];
    logic [1:0]       present;
    logic             turn;

    // A channel that is off or failed hands its turn straight back.
    always_ff @(posedge ref_clk)
    begin
        if (dev_rst || reinit)
            turn <= 1'b0;
        else if (!scan_fitted && (done[turn] || !active[turn]))
            turn <= !turn;
    end

    // ------------------------------------------------------------------
    // Channels
    // ------------------------------------------------------------------
    for (genvar i = 0; i < 2; i++)
    begin : g_ch
        logic [EDGE_W-1:0] cycles;
        logic [CNT_W-1:0]  target_ticks;
        logic [CNT_W-1:0]  short_lim;
        logic [CNT_W-1:0]  thresh;
        logic              detect;
        logic              ref_valid;
        logic              present_prev;
        logic [MS_W-1:0]   hold_ms;
        logic [MS_W-1:0]   pulse_ms;

        assign active[i]    = (state[i] == CH_TUNE) || (state[i] == CH_RUN);
        assign run[i]       = active[i] && (scan_fitted || turn == 1'(i));
        assign target_ticks = CNT_W'(SAMPLE_TICKS) << (sens[i] - 3'd1);
        assign short_lim    = CNT_W'(cycles * SHORT_MIN_TICKS);
        assign thresh       = ref_val[i] >> (THRESH_SHIFT_BASE + int'(sens[i]));
        assign detect       = (ref_val[i] > ticks[i])
                           && (ref_val[i] - ticks[i] > thresh);

        loop_period_counter u_counter
        (
            .ref_clk      (ref_clk),
            .srst         (dev_rst),
            .run          (run[i]),
            .tune         (state[i] == CH_TUNE),
            .tick         (tick),
            .ms_tick      (ms_tick),
            .loop_rise    (loop_rise[i]),
            .target_ticks (target_ticks),
            .target_edges (cycles),
            .done         (done[i]),
            .open_fault   (open_fault[i]),
            .sample_ticks (ticks[i]),
            .sample_edges (edges[i])
        );

        always_ff @(posedge ref_clk)
        begin
            if (dev_rst || reinit)
            begin
                state[i]  <= (sens[i] == 3'd0) ? CH_OFF : CH_TUNE;
                fault[i]  <= FAULT_NONE;
                cycles    <= '0;
                ref_valid <= 1'b0;
                ref_val[i] <= '0;
                present[i] <= 1'b0;
            end
            else
            begin
                unique case (state[i])
                    CH_OFF:
                    begin
                        present[i] <= 1'b0;
                    end
                    CH_TUNE:
                    begin
                        if (open_fault[i])
                        begin
                            state[i] <= CH_FAIL;
                            fault[i] <= FAULT_OPEN;
                        end
                        else if (done[i])
                        begin
                            // Cycles per sample follow from loop frequency.
                            if (edges[i] == '0)
                            begin
                                state[i] <= CH_FAIL;
                                fault[i] <= FAULT_OPEN;
                            end
                            else if (CNT_W'(edges[i] * SHORT_MIN_TICKS) > ticks[i])
                            begin
                                state[i] <= CH_FAIL;
                                fault[i] <= FAULT_SHORT;
                            end
                            else
                            begin
                                cycles   <= edges[i];
                                state[i] <= CH_RUN;
                            end
                        end
                    end
                    CH_RUN:
                    begin
                        if (open_fault[i])
                        begin
                            state[i]   <= CH_FAIL;
                            fault[i]   <= FAULT_OPEN;
                            present[i] <= 1'b0;
                        end
                        else if (done[i] && ticks[i] < short_lim)
                        begin
                            state[i]   <= CH_FAIL;
                            fault[i]   <= FAULT_SHORT;
                            present[i] <= 1'b0;
                        end
                        else if (done[i] && !ref_valid)
                        begin
                            ref_val[i] <= ticks[i];
                            ref_valid  <= 1'b1;
                        end
                        else if (done[i])
                        begin
                            present[i] <= detect;
                            // One count per sample keeps a vehicle from being
                            // absorbed while drift is still followed.
                            if (!detect && !drift_hold && ref_val[i] < ticks[i])
                                ref_val[i] <= ref_val[i] + 1'b1;
                            else if (!detect && !drift_hold && ref_val[i] > ticks[i])
                                ref_val[i] <= ref_val[i] - 1'b1;
                        end
                    end
                    CH_FAIL:
                    begin
                        present[i] <= 1'b0;
                    end
                endcase
            end
        end

        // Call shaping: minimum presence hold and single arrival pulse.
        always_ff @(posedge ref_clk)
        begin
            if (dev_rst || reinit)
            begin
                present_prev <= 1'b0;
                hold_ms      <= '0;
                pulse_ms     <= '0;
                call_out[i]  <= 1'b0;
                call_led[i]  <= 1'b0;
            end
            else
            begin
                present_prev <= present[i];
                if (present[i] && !present_prev)
                    hold_ms <= MIN_HOLD_MS;
                else if (ms_tick && hold_ms != '0)
                    hold_ms <= hold_ms - 1'b1;
                if (present[i] && !present_prev)
                    pulse_ms <= PULSE_MS;
                else if (ms_tick && pulse_ms != '0)
                    pulse_ms <= pulse_ms - 1'b1;
                if (pulse_mode[i])
                begin
                    call_out[i] <= pulse_ms != '0;
                    call_led[i] <= pulse_ms != '0;
                end
                else
                begin
                    call_out[i] <= present[i] || (hold_fitted && hold_ms != '0);
                    call_led[i] <= present[i] || (hold_fitted && hold_ms != '0);
                end
            end
        end

        fail_flasher u_flasher
        (
            .ref_clk (ref_clk),
            .srst    (dev_rst || reinit),
            .ms_tick (ms_tick),
            .fault   (fault[i]),
            .led     (fail_led[i])
        );
    end

    // ------------------------------------------------------------------
    // Register access
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (dev_rst)
        begin
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= '0;
            soft_reinit <= 1'b0;
            drift_hold  <= 1'b0;
        end
        else
        begin
            wb_ack_o    <= wb_hit;
            soft_reinit <= 1'b0;
            if (wb_hit && wb_we_i && wb_sel_i[0] && wb_adr_i == ADDR_CONTROL)
            begin
                soft_reinit <= wb_dat_i[CTRL_REINIT_BIT];
                drift_hold  <= wb_dat_i[CTRL_DRIFT_HOLD_BIT];
            end
            if (wb_hit && !wb_we_i)
            begin
                unique case (wb_adr_i)
                    ADDR_CONTROL: wb_dat_o <= {30'h0000_0000, drift_hold, 1'b0};
                    ADDR_STATUS:  wb_dat_o <= {16'h0000, state[1], state[0], fault[1],
                                               fault[0], 2'b00, present, 2'b00, call_out};
                    ADDR_REF0:    wb_dat_o <= {8'h00, ref_val[0]};
                    ADDR_REF1:    wb_dat_o <= {8'h00, ref_val[1]};
                    default:      wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

/* File: tb/loop_osc_model.sv */
/* Roadway loop oscillator model: one squared loop signal.
   A half period of zero models an open loop; the squared line then rests low. */
`default_nettype none
module loop_osc_model
(
    input  wire logic        ref_clk,
    input  wire logic [15:0] half_cycles,
    output logic             loop_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] cnt = 16'h0000;
    initial loop_line = 1'b0;
    always @(posedge ref_clk)
    begin
        cnt <= (cnt + 16'h0001 >= half_cycles) ? 16'h0000 : cnt + 16'h0001;
        if (half_cycles == 16'h0000)
            loop_line <= 1'b0;
        else if (cnt + 16'h0001 >= half_cycles)
            loop_line <= ~loop_line;
    end
endmodule
`default_nettype wire

/* File: tb/loop_detector_asserts.sv */
/* Port assertions for the loop detector, bound to every detector instance.
   Assumes one bus request at a time. */
`default_nettype none
module loop_detector_asserts
    import loop_detector_pkg::*;
#(parameter int MS_COUNT = MS_CYCLES)
(
    input wire logic       ref_clk,
    input wire logic       srst,
    input wire logic       hold_link,
    input wire logic [1:0] pulse_sw,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [1:0] call_out,
    input wire logic [1:0] call_led,
    input wire logic [1:0] fail_led
);
    logic [31:0] high_cnt = 32'h0000_0000;
    always_ff @(posedge ref_clk)
        high_cnt <= call_out[0] ? high_cnt + 32'h0000_0001 : 32'h0000_0000;
    default clocking @(posedge ref_clk);
    endclocking
    default disable iff (srst);
    sequence req_taken;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    a_ack_follows: assert property (req_taken |=> wb_ack_o) else $error("no ack");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o) else $error("long ack");
    a_ack_idle: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o) else $error("stray ack");
    a_led_mirror: assert property (call_led == call_out) else $error("led differs");
    a_fail_no_call: assert property ((fail_led & call_out) == 2'b00) else $error("call in fail");
    a_flash_on: assert property ($rose(fail_led[1]) |-> fail_led[1] [*8]) else $error("short flash");
    a_min_hold: assert property ($fell(call_out[0]) && hold_link && !pulse_sw[0]
        |-> high_cnt >= 32'(99 * MS_COUNT)) else $error("call too short");
    a_reset_clears: assert property ($fell(srst)
        |-> call_out == 2'b00 && fail_led == 2'b00 && !wb_ack_o) else $error("reset left output");
endmodule
bind dual_loop_vehicle_detector loop_detector_asserts #(.MS_COUNT(MS_COUNT)) checks
    (.ref_clk, .srst, .hold_link, .pulse_sw, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .call_out,
     .call_led, .fail_led);
`default_nettype wire

/* File: tb/tb_dual_loop_vehicle_detector.sv */
/* Bench for the dual loop detector: register rows, then fault, call and reset cases.
   Assumes two oscillator models stand in for the roadway loops. */
`default_nettype none
module tb_dual_loop_vehicle_detector;
    import loop_detector_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    // A 400-clock millisecond keeps the open timeout above a loop period; samples span ten.
    localparam int MS = 400;
    typedef struct {logic we; logic [7:0] adr; logic [31:0] wdat, exp;} row_type;
    row_type rows [6] = '{'{1'b1, 8'h10, 32'h0000_00ff, 32'h0000_0000},
        '{1'b0, 8'h10, 32'h0000_0000, 32'h0000_0000},
        '{1'b1, ADDR_CONTROL, 32'h0000_0003, 32'h0000_0000},
        '{1'b0, ADDR_CONTROL, 32'h0000_0000, 32'h0000_0002},
        '{1'b1, ADDR_CONTROL, 32'h0000_0000, 32'h0000_0000},
        '{1'b0, ADDR_STATUS, 32'h0000_0000, 32'h0000_5000}};
    logic ref_clk = 1'b0, srst = 1'b1, ext_reset_n = 1'b1, hold_link = 1'b1, scan_link = 1'b1;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, wb_ack_o;
    logic [1:0] pulse_sw = 2'b00, sens_weight_one = 2'b11, sens_weight_two = 2'b00;
    logic [1:0] sens_weight_four = 2'b00, loop_sq, call_out, call_led, fail_led;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'h0;
    logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, rd;
    logic [15:0] half0 = 16'h0113, half1 = 16'h0000;
    int fails = 0, check_count = 0, k;
    always #5 ref_clk = ~ref_clk;
    loop_osc_model osc0 (.ref_clk, .half_cycles(half0), .loop_line(loop_sq[0]));
    loop_osc_model osc1 (.ref_clk, .half_cycles(half1), .loop_line(loop_sq[1]));
    dual_loop_vehicle_detector #(.MS_COUNT(MS), .SAMPLE_TICKS(1100)) uut (.*);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            fails++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, a, 4'hf, d};
        do @(posedge ref_clk); while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
    endtask
    task print_verdict;
        $display("checks=%0d fails=%0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (90000) @(posedge ref_clk);
        fails++;
        print_verdict();
    end
    initial
    begin
        repeat (16) @(posedge ref_clk);
        srst <= 1'b0;
        repeat (2) @(posedge ref_clk);
        foreach (rows[i])
        begin
            bus(rows[i].we, rows[i].adr, rows[i].wdat);
            if (!rows[i].we) chk(rd, rows[i].exp);
        end
        for (k = 0; k < 2000 && fail_led[1] !== 1'b1; k++) @(posedge ref_clk);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk({fail_led[1], rd[11:8]}, 5'h14);
        rd = 32'h0000_0000;
        for (k = 0; k < 3000 && rd === 32'h0000_0000; k++)
        begin
            repeat (10) @(posedge ref_clk);
            bus(1'b0, ADDR_REF0, 32'h0000_0000);
        end
        half0 <= 16'h010e;
        for (k = 0; k < 25000 && call_out[0] !== 1'b1; k++) @(posedge ref_clk);
        chk({call_out, call_led}, 4'h5);
        half0 <= 16'h0113;
        for (k = 0; k < 60000 && call_out[0] !== 1'b0; k++) @(posedge ref_clk);
        {half1, pulse_sw[1]} <= {16'h0014, 1'b1};
        repeat (10) @(posedge ref_clk);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk({call_out[0], rd[11:10]}, 3'b000);
        pulse_sw[1] <= 1'b0;
        repeat (10) @(posedge ref_clk);
        for (k = 0; k < 8000 && fail_led[1] !== 1'b1; k++) @(posedge ref_clk);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk({fail_led[1], rd[11:10]}, 3'b110);
        repeat (10) @(posedge ref_clk);
        ext_reset_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        chk({call_out, fail_led}, 4'h0);
        {ext_reset_n, sens_weight_one[1]} <= 2'b10;
        repeat (30) @(posedge ref_clk);
        bus(1'b0, ADDR_STATUS, 32'h0000_0000);
        chk({fail_led[1], call_out[1], rd[15:14]}, 4'h0);
        print_verdict();
    end
endmodule
`default_nettype wire
